// ==== rtl/phy_mac_pin_strap_mux.sv ====
// MAC-side pin mux with power-up strap capture and interrupt pin.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Behaviour
// - RXD1 strap becomes management address bit 2.
// - RXD0 strap loads duplex, control bit 8.
// - RX_DV strap becomes interface config bit 2.
// - RX_ER strap sets initial isolate.
// - Interrupt polarity from bit 9 of 1Fh.
// - Interrupt only for conditions enabled in 1Bh.
// - TX clock output in MII only, input in RMII, SMII and back-to-back.
// - MII drives four-bit nibble, valid, error, clock.
// - RMII two-bit data, CRS_DV and error.
// - SMII serial RX on RXD0 only.
// - RXD3 and RXD2 strap address bits 0, 1.
module phy_mac_pin_strap_mux (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire pin_mux_pkg::rx_pins_t core_rx,
  input  wire logic                  core_rx_clk,
  input  wire logic                  core_tx_clk,
  input  wire logic [7:0]            core_events,
  output pin_mux_pkg::tx_pins_t      core_tx,
  output logic                       smii_sync,
  output logic                       tx_clk_in,
  input  wire pin_mux_pkg::rx_pins_t rx_pin_i,
  output pin_mux_pkg::rx_pins_t      rx_pin_o,
  output logic      [5:0]            rx_pin_oe_n,
  output logic                       rx_clk_pin,
  input  wire logic                  tx_clk_pin_i,
  output logic                       tx_clk_pin_o,
  output logic                       tx_clk_pin_oe_n,
  input  wire pin_mux_pkg::tx_pins_t tx_pin_i,
  output logic                       irq_out_pin
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [5:0] rx_pin_s;
  logic [4:0] tx_pin_s;
  logic       tx_clk_s;

  sync2 #(.W(12)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       ({rx_pin_i, tx_pin_i, tx_clk_pin_i}),
    .q       ({rx_pin_s, tx_pin_s, tx_clk_s})
  );

  // ==========================================================================
  // Strap capture after reset
  // ==========================================================================
  typedef enum logic [1:0] {ST_SETTLE, ST_RUN} strap_state_t;
  strap_state_t          st_r,     st_nxt;
  logic [3:0]            cnt_r,    cnt_nxt;
  pin_mux_pkg::straps_t  strap_r,  strap_nxt;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    strap_nxt = strap_r;
    if (ce) begin
      case (st_r)
        ST_SETTLE: begin
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == pin_mux_pkg::STRAP_CYCLES) begin
            strap_nxt.phy_mgmt_address = {2'h0, rx_pin_s[3], rx_pin_s[4],
                                          rx_pin_s[5]};
            strap_nxt.phy_mgmt_address[2] = rx_pin_s[3];
            strap_nxt.phy_mgmt_address[1] = rx_pin_s[4];
            strap_nxt.phy_mgmt_address[0] = rx_pin_s[5];
            strap_nxt.duplex               = rx_pin_s[2];
            strap_nxt.iface_cfg_strap_bit2 = rx_pin_s[1];
            strap_nxt.isolate              = rx_pin_s[0];
            st_nxt = ST_RUN;
          end
        end
        ST_RUN:  st_nxt = ST_RUN;
        default: st_nxt = ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r    <= ST_SETTLE;
      cnt_r   <= 4'h0;
      strap_r <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      strap_r <= strap_nxt;
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [15:0] ctrl0_r,  ctrl0_nxt;
  logic [15:0] ctl2_r,   ctl2_nxt;
  logic [7:0]  irq_en_r, irq_en_nxt;
  logic [1:0]  mode_r,   mode_nxt;
  logic [15:0] rdata_nxt;
  logic [7:0]  irq_clr;
  logic [7:0]  irq_status;
  logic        loaded;

  assign loaded = (st_r == ST_SETTLE) && ce && (cnt_r == pin_mux_pkg::STRAP_CYCLES);

  always_comb begin
    ctrl0_nxt  = ctrl0_r;
    ctl2_nxt   = ctl2_r;
    irq_en_nxt = irq_en_r;
    mode_nxt   = mode_r;
    rdata_nxt  = reg_rdata;
    irq_clr    = 8'h00;
    if (ce) begin
      if (loaded) begin
        ctrl0_nxt[pin_mux_pkg::DUPLEX_BIT]  = strap_nxt.duplex;
        ctrl0_nxt[pin_mux_pkg::ISOLATE_BIT] = strap_nxt.isolate;
      end
      rdata_nxt = 16'h0000;
      if (reg_wr) begin
        case (reg_addr)
          pin_mux_pkg::REG_CTRL0:    ctrl0_nxt = reg_wdata;
          pin_mux_pkg::REG_PHY_CTL2: ctl2_nxt  = reg_wdata;
          pin_mux_pkg::REG_IRQ_CS: begin
            irq_en_nxt = reg_wdata[pin_mux_pkg::IRQ_EN_LSB +: pin_mux_pkg::IRQ_NUM];
            irq_clr    = reg_wdata[7:0];
          end
          pin_mux_pkg::REG_MODE:     mode_nxt  = reg_wdata[1:0];
          default:                   irq_clr   = 8'h00;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          pin_mux_pkg::REG_CTRL0:    rdata_nxt = ctrl0_r;
          pin_mux_pkg::REG_PHY_CTL2: rdata_nxt = ctl2_r;
          pin_mux_pkg::REG_IRQ_CS:   rdata_nxt = {irq_en_r, irq_status};
          pin_mux_pkg::REG_MODE:     rdata_nxt = {14'h0000, mode_r};
          pin_mux_pkg::REG_STRAPS:   rdata_nxt = {8'h00, strap_r};
          default:                   rdata_nxt = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl0_r   <= pin_mux_pkg::CTRL0_RST;
      ctl2_r    <= pin_mux_pkg::PHY_CTL2_RST;
      irq_en_r  <= pin_mux_pkg::IRQ_EN_RST;
      mode_r    <= pin_mux_pkg::MODE_RST;
      reg_rdata <= 16'h0000;
    end else begin
      ctrl0_r   <= ctrl0_nxt;
      ctl2_r    <= ctl2_nxt;
      irq_en_r  <= irq_en_nxt;
      mode_r    <= mode_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Interrupt
  // ==========================================================================
  irq_unit u_irq (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .events      (core_events),
    .clr         (irq_clr),
    .enable      (irq_en_r),
    .active_high (ctl2_r[pin_mux_pkg::IRQ_POL_BIT]),
    .status      (irq_status),
    .irq_out_pin (irq_out_pin)
  );

  // ==========================================================================
  // Pin mux
  // ==========================================================================
  pin_mux_pkg::rx_pins_t rx_o_nxt;
  logic [5:0]            oe_n_nxt;
  logic                  rxc_nxt, txc_o_nxt, txc_oe_n_nxt;
  pin_mux_pkg::tx_pins_t core_tx_nxt;
  logic                  sync_nxt, txc_in_nxt;
  logic                  drive;

  // Reference clock rates of 25, 50 and 125 MHz are supplied outside.
  always_comb begin
    drive        = (st_r == ST_RUN) && !ctrl0_r[pin_mux_pkg::ISOLATE_BIT];
    rx_o_nxt     = rx_pin_o;
    oe_n_nxt     = rx_pin_oe_n;
    rxc_nxt      = rx_clk_pin;
    txc_o_nxt    = tx_clk_pin_o;
    txc_oe_n_nxt = tx_clk_pin_oe_n;
    core_tx_nxt  = core_tx;
    sync_nxt     = smii_sync;
    txc_in_nxt   = tx_clk_in;
    if (ce) begin
      rx_o_nxt     = core_rx;
      rxc_nxt      = core_rx_clk;
      txc_o_nxt    = core_tx_clk;
      txc_in_nxt   = tx_clk_s;
      sync_nxt     = 1'b0;
      core_tx_nxt  = tx_pin_s;
      oe_n_nxt     = 6'h3F;
      txc_oe_n_nxt = 1'b1;
      case (pin_mux_pkg::iface_mode_t'(mode_r))
        pin_mux_pkg::MODE_MII: begin
          if (drive) oe_n_nxt = 6'h00;
          txc_oe_n_nxt = !drive;
        end
        pin_mux_pkg::MODE_B2B: begin
          if (drive) oe_n_nxt = 6'h00;
        end
        pin_mux_pkg::MODE_RMII: begin
          if (drive) oe_n_nxt = 6'h30;
          core_tx_nxt.txd = {2'h0, tx_pin_s[2:1]};
        end
        pin_mux_pkg::MODE_SMII: begin
          if (drive) oe_n_nxt = 6'h3B;
          core_tx_nxt = {3'h0, tx_pin_s[1], 1'b0};
          sync_nxt    = tx_pin_s[2];
        end
        default: oe_n_nxt = 6'h3F;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_pin_o        <= '0;
      rx_pin_oe_n     <= 6'h3F;
      rx_clk_pin      <= 1'b0;
      tx_clk_pin_o    <= 1'b0;
      tx_clk_pin_oe_n <= 1'b1;
      core_tx         <= '0;
      smii_sync       <= 1'b0;
      tx_clk_in       <= 1'b0;
    end else begin
      rx_pin_o        <= rx_o_nxt;
      rx_pin_oe_n     <= oe_n_nxt;
      rx_clk_pin      <= rxc_nxt;
      tx_clk_pin_o    <= txc_o_nxt;
      tx_clk_pin_oe_n <= txc_oe_n_nxt;
      core_tx         <= core_tx_nxt;
      smii_sync       <= sync_nxt;
      tx_clk_in       <= txc_in_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_strap_hold_off: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_SETTLE) |=> (rx_pin_oe_n == 6'h3F))
    else $error("Strap pins driven before sampling.");
  a_duplex_load: assert property (@(posedge clk) disable iff (sys_rst)
    loaded |=> (ctrl0_r[pin_mux_pkg::DUPLEX_BIT] == $past(rx_pin_s[2])))
    else $error("Duplex strap not loaded.");
  a_addr_bit2: assert property (@(posedge clk) disable iff (sys_rst)
    loaded |=> (strap_r.phy_mgmt_address[2] == $past(rx_pin_s[3])))
    else $error("Address bit 2 strap wrong.");
  a_irq_polarity: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !(|(irq_status & irq_en_r))) |=>
      (irq_out_pin == !$past(ctl2_r[pin_mux_pkg::IRQ_POL_BIT])))
    else $error("Idle interrupt level wrong.");
  a_irq_enabled: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && (|(irq_status & irq_en_r))) |=>
      (irq_out_pin == $past(ctl2_r[pin_mux_pkg::IRQ_POL_BIT])))
    else $error("Enabled interrupt not asserted.");
  a_smii_rx_only0: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && mode_r == 2'h2) |=> (rx_pin_oe_n[5:3] == 3'h7 && rx_pin_oe_n[1:0] == 2'h3))
    else $error("Extra receive pins driven in SMII.");
  a_b2b_txc_in: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && mode_r == 2'h3) |=> tx_clk_pin_oe_n)
    else $error("Transmit clock driven in back-to-back.");
  a_mii_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && drive && mode_r == 2'h0) |=> (rx_pin_oe_n == 6'h00 && !tx_clk_pin_oe_n))
    else $error("MII outputs not driven.");
  a_isolate_load: assert property (@(posedge clk) disable iff (sys_rst)
    loaded |=> (ctrl0_r[pin_mux_pkg::ISOLATE_BIT] == $past(rx_pin_s[0])))
    else $error("Isolate strap not loaded.");
  a_cfg2_load: assert property (@(posedge clk) disable iff (sys_rst)
    loaded |=> (strap_r.iface_cfg_strap_bit2 == $past(rx_pin_s[1])))
    else $error("Interface config strap wrong.");
  a_addr_low_bits: assert property (@(posedge clk) disable iff (sys_rst)
    loaded |=> (strap_r.phy_mgmt_address[1:0] == {$past(rx_pin_s[4]), $past(rx_pin_s[5])}))
    else $error("Address bits 0 and 1 strap wrong.");
  a_rmii_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && drive && mode_r == 2'h1) |=> (rx_pin_oe_n == 6'h30))
    else $error("RMII receive pins driven wrong.");

  // Strap load followed by the first running cycle.
  sequence s_strap_done;
    loaded ##1 (st_r == ST_RUN);
  endsequence
  a_strap_enable: assert property (@(posedge clk) disable iff (sys_rst)
    (s_strap_done ##0 (ce && drive && mode_r == 2'h0)) |=> (rx_pin_oe_n == 6'h00))
    else $error("Pins not enabled after strap sampling.");

endmodule // phy_mac_pin_strap_mux

// ==== rtl/pin_mux_pkg.sv ====
// Shared constants, register map and carrier types for the MAC-side pin mux.
package pin_mux_pkg;

  // ==========================================================================
  // Interface modes
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_MII  = 2'h0,
    MODE_RMII = 2'h1,
    MODE_SMII = 2'h2,
    MODE_B2B  = 2'h3
  } iface_mode_t;

  // ==========================================================================
  // Register map (word index, byte address is four times the index)
  // ==========================================================================
  localparam logic [4:0] REG_CTRL0    = 5'h00;
  localparam logic [4:0] REG_IRQ_CS   = 5'h1B;
  localparam logic [4:0] REG_PHY_CTL2 = 5'h1F;
  localparam logic [4:0] REG_STRAPS   = 5'h10;
  localparam logic [4:0] REG_MODE     = 5'h11;

  localparam int DUPLEX_BIT    = 8;
  localparam int ISOLATE_BIT   = 10;
  localparam int IRQ_POL_BIT   = 9;
  localparam int IRQ_EN_LSB    = 8;
  localparam int IRQ_NUM       = 8;

  localparam logic [15:0] CTRL0_RST    = 16'h0000;
  localparam logic [15:0] PHY_CTL2_RST = 16'h0000;
  localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
  localparam logic [1:0]  MODE_RST     = 2'h0;

  // Cycles held after reset before strap pins are sampled and released.
  localparam int          STRAP_SETTLE_NS  = 64;
  localparam int          CLK_PERIOD_NS    = 8;
  localparam int          STRAP_CYC_INT    = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  STRAP_CYCLES     = 4'(STRAP_CYC_INT);

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
  } rx_pins_t;

  typedef struct packed {
    logic [3:0] txd;
    logic       tx_en;
  } tx_pins_t;

  typedef struct packed {
    logic [4:0] phy_mgmt_address;
    logic       iface_cfg_strap_bit2;
    logic       duplex;
    logic       isolate;
  } straps_t;

endpackage

// ==== rtl/sync2.sv ====
// Two flip-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = ce ? d : meta_r;
    q_nxt    = ce ? meta_r : q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule // sync2

// ==== rtl/irq_unit.sv ====
// Sticky interrupt status, enable mask and polarity-selected interrupt pin.
`timescale 1ns/1ps
module irq_unit (
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic                            ce,
  input  wire logic [pin_mux_pkg::IRQ_NUM-1:0] events,
  input  wire logic [pin_mux_pkg::IRQ_NUM-1:0] clr,
  input  wire logic [pin_mux_pkg::IRQ_NUM-1:0] enable,
  input  wire logic                            active_high,
  output logic      [pin_mux_pkg::IRQ_NUM-1:0] status,
  output logic                                 irq_out_pin
);
  logic [pin_mux_pkg::IRQ_NUM-1:0] status_nxt;
  logic                            pin_nxt;

  always_comb begin
    status_nxt = status;
    pin_nxt    = irq_out_pin;
    if (ce) begin
      status_nxt = (status & ~clr) | events;
      pin_nxt    = (|(status & enable)) ~^ active_high;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status      <= '0;
      irq_out_pin <= 1'b1;
    end else begin
      status      <= status_nxt;
      irq_out_pin <= pin_nxt;
    end
  end
endmodule // irq_unit

// ==== verification/mac_model.sv ====
// Behavioural MAC on the far side of the pin mux, with pin resolution.
`timescale 1ns/1ps
module mac_model (
  input  wire logic                  link_run,
  input  wire logic [5:0]            pulls,
  input  wire pin_mux_pkg::tx_pins_t tx_val,
  input  wire pin_mux_pkg::rx_pins_t rx_pin_o,
  input  wire logic [5:0]            rx_pin_oe_n,
  input  wire logic                  tx_clk_pin_o,
  input  wire logic                  tx_clk_pin_oe_n,
  output pin_mux_pkg::rx_pins_t      rx_wire,
  output pin_mux_pkg::tx_pins_t      tx_wire,
  output logic                       tx_clk_wire
);
  logic link_clk;

  // ==========================================================================
  // Link clock, standing still between frames
  // ==========================================================================
  initial begin
    link_clk = 1'b0;
    forever begin
      #40;
      link_clk = link_run ? ~link_clk : 1'b0;
    end
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  // An undriven receive pin settles to its strap pull level.
  assign rx_wire = (rx_pin_oe_n & pulls) | (~rx_pin_oe_n & rx_pin_o);
  // The MAC drives nibble, enable, serial data and sync.
  assign tx_wire = tx_val;
  // The MAC supplies the transmit clock only while the device leaves it.
  assign tx_clk_wire = tx_clk_pin_oe_n ? link_clk : tx_clk_pin_o;
endmodule // mac_model

// ==== verification/tb_phy_mac_pin_strap_mux.sv ====
// Self-checking testbench for the MAC-side pin mux.
`timescale 1ns/1ps
module tb_phy_mac_pin_strap_mux;
  logic                  clk, sys_rst, ce, reg_wr, reg_rd, core_rx_clk, core_tx_clk;
  logic                  link_run, smii_sync, tx_clk_in, rx_clk_pin, irq_out_pin;
  logic                  tx_clk_pin_o, tx_clk_pin_oe_n, tx_clk_w;
  logic [4:0]            reg_addr;
  logic [15:0]           reg_wdata, reg_rdata, rd_val;
  logic [7:0]            core_events;
  logic [5:0]            pulls, rx_pin_oe_n;
  pin_mux_pkg::rx_pins_t core_rx, rx_pin_o, rx_w;
  pin_mux_pkg::tx_pins_t core_tx, tx_val, tx_w;
  int                    num_errors, num_checks;

  phy_mac_pin_strap_mux i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_rx(core_rx), .core_rx_clk(core_rx_clk), .core_tx_clk(core_tx_clk),
    .core_events(core_events), .core_tx(core_tx), .smii_sync(smii_sync),
    .tx_clk_in(tx_clk_in), .rx_pin_i(rx_w), .rx_pin_o(rx_pin_o), .rx_pin_oe_n(rx_pin_oe_n),
    .rx_clk_pin(rx_clk_pin), .tx_clk_pin_i(tx_clk_w), .tx_clk_pin_o(tx_clk_pin_o),
    .tx_clk_pin_oe_n(tx_clk_pin_oe_n), .tx_pin_i(tx_w), .irq_out_pin(irq_out_pin));

  mac_model i_mac (.link_run(link_run), .pulls(pulls), .tx_val(tx_val), .rx_pin_o(rx_pin_o),
    .rx_pin_oe_n(rx_pin_oe_n), .tx_clk_pin_o(tx_clk_pin_o),
    .tx_clk_pin_oe_n(tx_clk_pin_oe_n), .rx_wire(rx_w), .tx_wire(tx_w), .tx_clk_wire(tx_clk_w));

  // ==========================================================================
  // Common tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic strap_scenario(input logic [5:0] p);
    @(posedge clk);
    pulls   <= p;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("oe_n during straps", 16'h003F, rx_pin_oe_n);
    repeat (14) @(posedge clk);
    rd(pin_mux_pkg::REG_STRAPS);
    chk("addr bit0", p[5], rd_val[3]);
    chk("addr bit1", p[4], rd_val[4]);
    chk("addr bit2", p[3], rd_val[5]);
    chk("cfg bit2", p[1], rd_val[2]);
    chk("duplex strap", p[2], rd_val[1]);
    chk("isolate strap", p[0], rd_val[0]);
    rd(pin_mux_pkg::REG_CTRL0);
    chk("ctrl0 duplex", p[2], rd_val[8]);
    chk("ctrl0 isolate", p[0], rd_val[10]);
    chk("oe_n isolated", p[0] ? 16'h003F : 16'h0000, rx_pin_oe_n);
  endtask

  task automatic mode_scenario(input pin_mux_pkg::iface_mode_t m, input logic [4:0] tv);
    wr(pin_mux_pkg::REG_MODE, {14'h0000, m});
    tx_val      <= tv;
    core_rx     <= {tv[3:0], tv[4], ~tv[4]};
    core_rx_clk <= tv[0];
    core_tx_clk <= tv[1];
    repeat (6) @(posedge clk);
    #1;
    case (m)
      pin_mux_pkg::MODE_RMII: begin
        chk("rmii oe_n", 16'h0030, rx_pin_oe_n);
        chk("rmii rx", core_rx[3:0], rx_pin_o[3:0]);
        chk("rmii tx", {tv[2:1], tv[0]}, {core_tx.txd[1:0], core_tx.tx_en});
      end
      pin_mux_pkg::MODE_SMII: begin
        chk("smii oe_n", 16'h003B, rx_pin_oe_n);
        chk("smii rx", core_rx[2], rx_pin_o[2]);
        chk("smii tx", {tv[1], 1'b0}, {core_tx.txd[0], core_tx.tx_en});
        chk("smii sync", tv[2], smii_sync);
      end
      default: begin
        chk("mii oe_n", 16'h0000, rx_pin_oe_n);
        chk("mii rx", core_rx, rx_pin_o);
        chk("mii rx clk", tv[0], rx_clk_pin);
        chk("mii tx clk", tv[1], tx_clk_pin_o);
        chk("mii tx", tv, core_tx);
        chk("tx clk oe_n", m == pin_mux_pkg::MODE_B2B, tx_clk_pin_oe_n);
      end
    endcase
  endtask

  task automatic b2b_clock_scenario();
    int   edges;
    logic last;
    edges = 0;
    wr(pin_mux_pkg::REG_MODE, 16'h0003);
    link_run <= 1'b1;
    last = tx_clk_in;
    for (int i = 0; i < 60 && edges < 4; i++) begin
      @(posedge clk);
      #1;
      if (tx_clk_in !== last) edges++;
      last = tx_clk_in;
    end
    link_run <= 1'b0;
    chk("b2b clock edges", 16'h0004, 16'(edges));
    if (edges < 4) begin
      report_and_stop();
    end
  endtask

  task automatic pulse_event(input logic [7:0] ev);
    @(posedge clk);
    core_events <= ev;
    @(posedge clk);
    core_events <= 8'h00;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic irq_scenario();
    wr(pin_mux_pkg::REG_IRQ_CS, 16'h01FF);
    pulse_event(8'h02);
    chk("masked irq", 16'h0001, irq_out_pin);
    rd(pin_mux_pkg::REG_IRQ_CS);
    chk("irq status", 16'h0102, rd_val);
    pulse_event(8'h01);
    chk("irq active low", 16'h0000, irq_out_pin);
    wr(pin_mux_pkg::REG_PHY_CTL2, 16'h0200);
    repeat (3) @(posedge clk);
    #1;
    chk("irq active high", 16'h0001, irq_out_pin);
    wr(pin_mux_pkg::REG_IRQ_CS, 16'h0101);
    repeat (3) @(posedge clk);
    #1;
    chk("irq cleared", 16'h0000, irq_out_pin);
    rd(pin_mux_pkg::REG_IRQ_CS);
    chk("irq status left", 16'h0102, rd_val);
    rd(5'h05);
    chk("unmapped read", 16'h0000, rd_val);
  endtask

  task automatic freeze_scenario();
    @(posedge clk);
    ce          <= 1'b0;
    core_events <= 8'h01;
    repeat (3) @(posedge clk);
    #1;
    chk("frozen irq", 16'h0000, irq_out_pin);
    @(posedge clk);
    ce          <= 1'b1;
    core_events <= 8'h00;
    rd(pin_mux_pkg::REG_IRQ_CS);
    chk("frozen status", 16'h0102, rd_val);
  endtask

  // ==========================================================================
  // Clock and main sequence
  // ==========================================================================
  // The 125 MHz clock also stands in for the SMII reference rate.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    num_errors  = 0;
    num_checks  = 0;
    sys_rst     = 1'b1;
    ce          = 1'b1;
    reg_addr    = 5'h00;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    core_rx     = 6'h00;
    core_rx_clk = 1'b0;
    core_tx_clk = 1'b0;
    core_events = 8'h00;
    link_run    = 1'b0;
    pulls       = 6'h15;
    tx_val      = 5'h00;
    strap_scenario(6'h15);
    strap_scenario(6'h2A);
    for (int v = 0; v < 2; v++) begin
      for (int m = 0; m < 4; m++) begin
        mode_scenario(pin_mux_pkg::iface_mode_t'(m), v ? 5'h0A : 5'h15);
      end
    end
    b2b_clock_scenario();
    irq_scenario();
    freeze_scenario();
    report_and_stop();
  end
endmodule // tb_phy_mac_pin_strap_mux
